// File: rtl/pfs_cfg.svh
// Offsets, field positions, reset values and timing counts of the pin-function block
// Behaviour
// - Port D bit set selects data bus
// - ROM disabled forces port D to bus
// - Single-chip forces port D to GPIO
// - Sixteen-bit port E direction register
// - Direction one drives output, zero input
// - Other functions ignore the direction bit
// - Direction clears only on power-on reset
// - Two port E function-select registers
// - Mode may ignore bus-control or DMA-acknowledge selects
// - Function selects clear only on power-on
// - Port D selects clear only on power-on
// - Port D selects used only ROM-enabled extended
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// Word offsets on the register bus
`define PFS_OFS_PD_LOW_FUNC 3'h0
`define PFS_OFS_PE_DIR 3'h1
`define PFS_OFS_PE_UPPER_FUNC 3'h2
`define PFS_OFS_PE_LOWER_FUNC 3'h3
`define PFS_OFS_STATUS 3'h4
`define PFS_OFS_PD_EFFECTIVE 3'h5

// Reset values, all taken on power-on reset only
`define PFS_RST_PD_LOW_FUNC 16'h0000
`define PFS_RST_PE_DIR 16'h0000
`define PFS_RST_PE_UPPER_FUNC 16'h0000
`define PFS_RST_PE_LOWER_FUNC 16'h0000

// Writable bits; reserved bits stay zero
`define PFS_MASK_PE_UPPER_FUNC 16'hFD55
`define PFS_MASK_PE_LOWER_FUNC 16'h55FF

// Status register field positions
`define PFS_STAT_MODE_LSB 0
`define PFS_STAT_MODE_MSB 1

// Bus answer delay in cycles after a request is first seen
`define PFS_BUS_WAIT_CYCLES 1

// Avalon response codes
`define PFS_RESP_OKAY 2'h0
`define PFS_RESP_SLVERR 2'h2

`endif

// File: rtl/pfs_pkg.sv
// Types shared by the pin-function block
package pfs_pkg;

   // Operating mode, static while the part runs
   typedef enum logic [1:0] {
      PFS_MODE_EXT_NOROM = 2'b00,
      PFS_MODE_EXT_ROM = 2'b01,
      PFS_MODE_SINGLE = 2'b10
   } pfs_mode_t;

   // Port E pin function code
   typedef enum logic [1:0] {
      PFS_FN_GPIO = 2'b00,
      PFS_FN_TIMER = 2'b01,
      PFS_FN_ALT_A = 2'b10,
      PFS_FN_ALT_B = 2'b11
   } pfs_func_t;

   // Resolved state of one port E pin
   typedef struct packed {
      pfs_func_t func;
      logic dir_used;
      logic oe;
   } pfs_pe_pin_t;

endpackage

// File: rtl/pfs_pe_cell.sv
// Resolves the effective function and drive of one port E pin
`timescale 1ns/100ps
`include "pfs_cfg.svh"

module pfs_pe_cell
   import pfs_pkg::*;
#(
   parameter int PIN = 0
) (
   input wire logic [1:0] code_i, // Selected function code
   input wire logic dir_i, // Direction register bit
   input wire pfs_mode_t mode_i, // Operating mode
   output pfs_pe_pin_t pin_o // Resolved pin state
);

   pfs_func_t eff_func;

   always_comb begin
      eff_func = pfs_func_t'(code_i);
      // Bus-control and DMA-acknowledge outputs do not exist in single-chip mode
      if ((mode_i == PFS_MODE_SINGLE) && (PIN >= 14) && code_i[1]) begin
         eff_func = PFS_FN_GPIO;
      end
   end

   always_comb begin
      pin_o.func = eff_func;
      pin_o.dir_used = (eff_func == PFS_FN_GPIO) || (eff_func == PFS_FN_TIMER);
      pin_o.oe = pin_o.dir_used && dir_i;
   end

endmodule // pfs_pe_cell

// File: rtl/pfs_top.sv
// Port D / port E pin-function select registers with an Avalon-MM slave
`timescale 1ns/100ps
`include "pfs_cfg.svh"

module pfs_top
   import pfs_pkg::*;
#(
   parameter int PD_PINS = 16,
   parameter int PE_PINS = 16
) (
   input wire logic mclk_i, // System clock, 125 MHz
   input wire logic resetn_i, // Power-on reset, synchronous, active low
   input wire pfs_mode_t op_mode_i, // Static operating mode
   input wire logic [2:0] avs_address_i, // Word address
   input wire logic avs_read_i, // Read request
   input wire logic avs_write_i, // Write request
   input wire logic [31:0] avs_writedata_i, // Write data
   input wire logic [3:0] avs_byteenable_i, // Byte enables
   output logic [31:0] avs_readdata_o, // Read data
   output logic [1:0] avs_response_o, // Answer code
   output logic avs_waitrequest_o, // High until answer
   output logic [PD_PINS-1:0] pd_bus_sel_o, // Port D pin is data bus line
   output pfs_pe_pin_t [PE_PINS-1:0] pe_pin_o // Port E resolved pins
);

   logic [15:0] pd_func_q;
   logic [15:0] pe_dir_q;
   logic [15:0] pe_upper_q;
   logic [15:0] pe_lower_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [1:0] resp_q;
   logic [PD_PINS-1:0] pd_bus_q;
   pfs_pe_pin_t [PE_PINS-1:0] pe_pin_q;

   logic req;
   logic take;
   logic wr_take;
   logic mapped;
   logic [31:0] rdata_d;
   logic [PD_PINS-1:0] pd_bus_d;
   logic [1:0] pe_code [PE_PINS];
   pfs_pe_pin_t [PE_PINS-1:0] pe_pin_d;

   // Masks held at register width so each byte lane can be sliced from them
   localparam logic [15:0] UP_MASK = `PFS_MASK_PE_UPPER_FUNC;
   localparam logic [15:0] LO_MASK = `PFS_MASK_PE_LOWER_FUNC;

   assign req = avs_read_i || avs_write_i;
   assign take = req && !wait_q;
   assign wr_take = take && avs_write_i;

   // Bus handshake: every request waits exactly one cycle
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         wait_q <= 1'b1;
      end else if (req && wait_q) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= 1'b1;
      end
   end

   always_comb begin
      mapped = 1'b1;
      rdata_d = 32'h0000_0000;
      case (avs_address_i)
         `PFS_OFS_PD_LOW_FUNC: begin
            rdata_d[15:0] = pd_func_q;
         end
         `PFS_OFS_PE_DIR: begin
            rdata_d[15:0] = pe_dir_q;
         end
         `PFS_OFS_PE_UPPER_FUNC: begin
            rdata_d[15:0] = pe_upper_q;
         end
         `PFS_OFS_PE_LOWER_FUNC: begin
            rdata_d[15:0] = pe_lower_q;
         end
         `PFS_OFS_STATUS: begin
            rdata_d[`PFS_STAT_MODE_MSB:`PFS_STAT_MODE_LSB] = op_mode_i;
         end
         `PFS_OFS_PD_EFFECTIVE: begin
            rdata_d[PD_PINS-1:0] = pd_bus_q;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // Read data and answer code are captured while waitrequest is still high
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         rdata_q <= 32'h0000_0000;
         resp_q <= `PFS_RESP_OKAY;
      end else if (req && wait_q) begin
         rdata_q <= avs_read_i ? rdata_d : 32'h0000_0000;
         resp_q <= mapped ? `PFS_RESP_OKAY : `PFS_RESP_SLVERR;
      end
   end

   // Only power-on reset clears these; other resets never reach this block
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         pd_func_q <= `PFS_RST_PD_LOW_FUNC;
      end else if (wr_take && (avs_address_i == `PFS_OFS_PD_LOW_FUNC)) begin
         if (avs_byteenable_i[0]) begin
            pd_func_q[7:0] <= avs_writedata_i[7:0];
         end
         if (avs_byteenable_i[1]) begin
            pd_func_q[15:8] <= avs_writedata_i[15:8];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         pe_dir_q <= `PFS_RST_PE_DIR;
      end else if (wr_take && (avs_address_i == `PFS_OFS_PE_DIR)) begin
         if (avs_byteenable_i[0]) begin
            pe_dir_q[7:0] <= avs_writedata_i[7:0];
         end
         if (avs_byteenable_i[1]) begin
            pe_dir_q[15:8] <= avs_writedata_i[15:8];
         end
      end
   end

   // Reserved bits are masked on write so they always read zero
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         pe_upper_q <= `PFS_RST_PE_UPPER_FUNC;
      end else if (wr_take && (avs_address_i == `PFS_OFS_PE_UPPER_FUNC)) begin
         if (avs_byteenable_i[0]) begin
            pe_upper_q[7:0] <= avs_writedata_i[7:0] & UP_MASK[7:0];
         end
         if (avs_byteenable_i[1]) begin
            pe_upper_q[15:8] <= avs_writedata_i[15:8] & UP_MASK[15:8];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         pe_lower_q <= `PFS_RST_PE_LOWER_FUNC;
      end else if (wr_take && (avs_address_i == `PFS_OFS_PE_LOWER_FUNC)) begin
         if (avs_byteenable_i[0]) begin
            pe_lower_q[7:0] <= avs_writedata_i[7:0] & LO_MASK[7:0];
         end
         if (avs_byteenable_i[1]) begin
            pe_lower_q[15:8] <= avs_writedata_i[15:8] & LO_MASK[15:8];
         end
      end
   end

   // Port D: mode decides, register only counts in ROM-enabled extended mode
   always_comb begin
      case (op_mode_i)
         PFS_MODE_EXT_NOROM: begin
            pd_bus_d = '1;
         end
         PFS_MODE_EXT_ROM: begin
            pd_bus_d = pd_func_q[PD_PINS-1:0];
         end
         PFS_MODE_SINGLE: begin
            pd_bus_d = '0;
         end
         default: begin
            pd_bus_d = '0;
         end
      endcase
   end

   // Function code per port E pin; upper register holds pins 15..8
   always_comb begin
      pe_code[15] = pe_upper_q[15:14];
      pe_code[14] = pe_upper_q[13:12];
      pe_code[13] = pe_upper_q[11:10];
      pe_code[12] = {1'b0, pe_upper_q[8]};
      pe_code[11] = {1'b0, pe_upper_q[6]};
      pe_code[10] = {1'b0, pe_upper_q[4]};
      pe_code[9] = {1'b0, pe_upper_q[2]};
      pe_code[8] = {1'b0, pe_upper_q[0]};
      pe_code[7] = {1'b0, pe_lower_q[14]};
      pe_code[6] = {1'b0, pe_lower_q[12]};
      pe_code[5] = {1'b0, pe_lower_q[10]};
      pe_code[4] = {1'b0, pe_lower_q[8]};
      pe_code[3] = pe_lower_q[7:6];
      pe_code[2] = pe_lower_q[5:4];
      pe_code[1] = pe_lower_q[3:2];
      pe_code[0] = pe_lower_q[1:0];
   end

   for (genvar gi = 0; gi < PE_PINS; gi++) begin : g_pe
      pfs_pe_cell #(
         .PIN(gi)
      ) u_cell (
         .code_i(pe_code[gi]),
         .dir_i(pe_dir_q[gi]),
         .mode_i(op_mode_i),
         .pin_o(pe_pin_d[gi])
      );
   end

   // Outputs are registered so pad muxes see glitch-free selects
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         pd_bus_q <= '0;
         pe_pin_q <= '0;
      end else begin
         pd_bus_q <= pd_bus_d;
         pe_pin_q <= pe_pin_d;
      end
   end

   assign avs_readdata_o = rdata_q;
   assign avs_response_o = resp_q;
   assign avs_waitrequest_o = wait_q;
   assign pd_bus_sel_o = pd_bus_q;
   assign pe_pin_o = pe_pin_q;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_req_seen;
      req && avs_waitrequest_o;
   endsequence

   sequence s_answer;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence

   bus_answer_a: assert property (s_req_seen |=> s_answer)
      else $error("bus answer not one cycle late");

   property p_por_clear;
      @(posedge mclk_i) !resetn_i |=> (pd_func_q == 16'h0000) && (pe_dir_q == 16'h0000)
         && (pe_upper_q == 16'h0000) && (pe_lower_q == 16'h0000);
   endproperty
   por_clear_a: assert property (disable iff (1'b0) p_por_clear)
      else $error("registers not cleared by power-on reset");

   dir_write_a: assert property (
      avs_write_i && !avs_waitrequest_o && (avs_address_i == `PFS_OFS_PE_DIR)
      && (avs_byteenable_i[1:0] == 2'b11)
      |=> pe_dir_q == $past(avs_writedata_i[15:0]))
      else $error("direction write lost");

   reserved_zero_a: assert property (
      ((pe_upper_q & ~`PFS_MASK_PE_UPPER_FUNC) == 16'h0000)
      && ((pe_lower_q & ~`PFS_MASK_PE_LOWER_FUNC) == 16'h0000))
      else $error("reserved bit set");

   pd_norom_a: assert property (
      (op_mode_i == PFS_MODE_EXT_NOROM) |=> (pd_bus_sel_o == '1))
      else $error("port D not on bus without ROM");

   pd_single_a: assert property (
      (op_mode_i == PFS_MODE_SINGLE) |=> (pd_bus_sel_o == '0))
      else $error("port D not GPIO in single-chip");

   pd_follow_a: assert property (
      (op_mode_i == PFS_MODE_EXT_ROM) |=> (pd_bus_sel_o == $past(pd_func_q[PD_PINS-1:0])))
      else $error("port D select not following register");

   pe_dir_out_a: assert property (
      !pe_code[0][1] |=> (pe_pin_o[0].oe == $past(pe_dir_q[0])))
      else $error("GPIO or timer pin drive not following direction");

   pe_dir_ign_a: assert property (
      pe_code[0][1] |=> !pe_pin_o[0].oe && !pe_pin_o[0].dir_used)
      else $error("direction honoured for other function");

   pe_single_a: assert property (
      (op_mode_i == PFS_MODE_SINGLE) && pe_code[15][1]
      |=> (pe_pin_o[15].func == PFS_FN_GPIO) && (pe_pin_o[15].oe == $past(pe_dir_q[15])))
      else $error("DMA acknowledge select kept in single-chip");

endmodule // pfs_top

// File: tb/pfs_top_tb.sv
// Self-checking testbench for the port D / port E pin-function block
`timescale 1ns/100ps
`include "pfs_cfg.svh"

module pfs_top_tb
   import pfs_pkg::*;
;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   pfs_mode_t op_mode_i = PFS_MODE_EXT_ROM;
   logic [2:0] avs_address_i = 3'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'h0;
   logic [31:0] avs_readdata_o;
   logic [1:0] avs_response_o;
   logic avs_waitrequest_o;
   logic [15:0] pd_bus_sel_o;
   pfs_pe_pin_t [15:0] pe_pin_o;
   int errors = 0;
   int checks_done = 0;

   always #4 mclk_i = ~mclk_i;

   pfs_top dut (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .op_mode_i(op_mode_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o),
      .avs_waitrequest_o(avs_waitrequest_o), .pd_bus_sel_o(pd_bus_sel_o), .pe_pin_o(pe_pin_o)
   );

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Request held until the rising edge that sees waitrequest low; data taken there
   task automatic bus(input logic wr, input logic [2:0] a, input logic [15:0] d,
                      input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rsp);
      int n;
      n = 0;
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      avs_writedata_i <= {16'hFFFF, d};
      avs_byteenable_i <= be;
      do begin
         @(posedge mclk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      if (n >= 50) begin
         errors++;
         $display("ERROR at %0t: bus answer missing", $time);
      end
      rd = avs_readdata_o;
      rsp = avs_response_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic [3:0] be);
      logic [31:0] rd;
      logic [1:0] rsp;
      bus(1'b1, a, d, be, rd, rsp);
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp, input logic [1:0] ersp);
      logic [31:0] rd;
      logic [1:0] rsp;
      bus(1'b0, a, 16'h0000, 4'hF, rd, rsp);
      chk({32'h0, rd}, {32'h0, exp});
      chk({62'h0, rsp}, {62'h0, ersp});
   endtask

   // Expected resolved port E pins from register contents and mode
   function automatic logic [63:0] pe_exp(input logic [15:0] dir, up, lo, input pfs_mode_t m);
      logic [1:0] c;
      logic [63:0] r;
      r = '0;
      for (int p = 0; p < 16; p++) begin
         if (p >= 13) c = up[2*p-15 -: 2];
         else if (p >= 8) c = {1'b0, up[2*(p-8)]};
         else if (p >= 4) c = {1'b0, lo[2*p]};
         else c = lo[2*p+1 -: 2];
         if (m == PFS_MODE_SINGLE && p >= 14 && c[1]) c = 2'b00;
         r[4*p +: 4] = {c, ~c[1], ~c[1] & dir[p]};
      end
      return r;
   endfunction

   task automatic t_clear();
      for (int a = 0; a < 4; a++)
         rd_chk(a[2:0], 32'h0, `PFS_RESP_OKAY);
      $display("test register_clear done");
   endtask

   task automatic t_pd_modes();
      pfs_mode_t m;
      wr(`PFS_OFS_PD_LOW_FUNC, 16'h2A5C, 4'h3);
      rd_chk(`PFS_OFS_PD_LOW_FUNC, 32'h2A5C, `PFS_RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         m = pfs_mode_t'(i[1:0]);
         op_mode_i <= m;
         repeat (3) @(posedge mclk_i);
         @(negedge mclk_i);
         if (m == PFS_MODE_EXT_NOROM) chk({48'h0, pd_bus_sel_o}, 64'hFFFF);
         else if (m == PFS_MODE_EXT_ROM) chk({48'h0, pd_bus_sel_o}, 64'h2A5C);
         else chk({48'h0, pd_bus_sel_o}, 64'h0);
         rd_chk(`PFS_OFS_STATUS, {30'h0, i[1:0]}, `PFS_RESP_OKAY);
      end
      op_mode_i <= PFS_MODE_EXT_ROM;
      $display("test port_d_modes done");
   endtask

   task automatic t_pe();
      logic [15:0] up_t[2] = '{16'hFFFF, 16'hA955};
      logic [15:0] lo_t[2] = '{16'hFFFF, 16'h5A96};
      wr(`PFS_OFS_PE_DIR, 16'hA5C3, 4'h3);
      rd_chk(`PFS_OFS_PE_DIR, 32'hA5C3, `PFS_RESP_OKAY);
      @(negedge mclk_i);
      chk(pe_pin_o, pe_exp(16'hA5C3, 16'h0, 16'h0, PFS_MODE_EXT_ROM));
      for (int i = 0; i < 2; i++) begin
         wr(`PFS_OFS_PE_UPPER_FUNC, up_t[i], 4'h3);
         wr(`PFS_OFS_PE_LOWER_FUNC, lo_t[i], 4'h3);
         rd_chk(`PFS_OFS_PE_UPPER_FUNC, {16'h0, up_t[i] & `PFS_MASK_PE_UPPER_FUNC},
                `PFS_RESP_OKAY);
         rd_chk(`PFS_OFS_PE_LOWER_FUNC, {16'h0, lo_t[i] & `PFS_MASK_PE_LOWER_FUNC},
                `PFS_RESP_OKAY);
         for (int k = 1; k < 3; k++) begin
            op_mode_i <= pfs_mode_t'(k[1:0]);
            repeat (3) @(posedge mclk_i);
            @(negedge mclk_i);
            chk(pe_pin_o, pe_exp(16'hA5C3, up_t[i], lo_t[i], pfs_mode_t'(k[1:0])));
         end
      end
      op_mode_i <= PFS_MODE_EXT_ROM;
      $display("test port_e_functions done");
   endtask

   task automatic t_bus_edges();
      logic [31:0] rd;
      logic [1:0] rsp;
      wr(`PFS_OFS_PE_DIR, 16'h00FF, 4'h1);
      rd_chk(`PFS_OFS_PE_DIR, 32'hA5FF, `PFS_RESP_OKAY);
      wr(`PFS_OFS_PE_DIR, 16'h5A00, 4'h2);
      rd_chk(`PFS_OFS_PE_DIR, 32'h5AFF, `PFS_RESP_OKAY);
      bus(1'b1, 3'h7, 16'h1234, 4'h3, rd, rsp);
      chk({62'h0, rsp}, {62'h0, `PFS_RESP_SLVERR});
      rd_chk(3'h7, 32'h0, `PFS_RESP_SLVERR);
      rd_chk(`PFS_OFS_PD_LOW_FUNC, 32'h2A5C, `PFS_RESP_OKAY);
      rd_chk(`PFS_OFS_PD_EFFECTIVE, 32'h2A5C, `PFS_RESP_OKAY);
      $display("test bus_edges done");
   endtask

   // Power-on reset in mid-run must clear every select register again
   task automatic t_por();
      @(posedge mclk_i);
      resetn_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      resetn_i <= 1'b1;
      t_clear();
      @(negedge mclk_i);
      chk({48'h0, pd_bus_sel_o}, 64'h0);
      $display("test power_on_reset done");
   endtask

   initial begin
      repeat (12) @(posedge mclk_i);
      resetn_i <= 1'b1;
      t_clear();
      t_pd_modes();
      t_pe();
      t_bus_edges();
      t_por();
      test_done();
   end

   initial begin
      repeat (20000) @(posedge mclk_i);
      errors++;
      $display("ERROR at %0t: run did not finish", $time);
      test_done();
   end
endmodule // pfs_top_tb
